//--- rtl/ims_pkg.sv
// Constants, carrier types and register map of the two-wire mode sequencer.
// Assumes a 50 MHz system clock and an 8-bit register port with two address bits.
package ims_pkg;
  // ------------------------------------------------------------
  // Register map and control fields
  // ------------------------------------------------------------
  localparam logic [1:0] IMS_ADDR_CONTROL = 2'h0;
  localparam logic [1:0] IMS_ADDR_OWN = 2'h1;
  localparam logic [1:0] IMS_ADDR_PROGRESS = 2'h2;
  localparam logic [1:0] IMS_ADDR_BYTE = 2'h3;
  localparam int IMS_CTL_ACK = 7;
  localparam int IMS_CTL_EN = 6;
  localparam int IMS_CTL_BEGIN = 5;
  localparam int IMS_CTL_HALT = 4;
  localparam int IMS_CTL_FLAG = 3;
  localparam logic [7:0] IMS_CONTROL_RST = 8'h00;
  localparam logic [7:0] IMS_OWN_RST = 8'h00;
  localparam logic [7:0] IMS_BYTE_RST = 8'h00;
  localparam logic [3:0] IMS_ACK_BIT = 4'h8;
  // ------------------------------------------------------------
  // Progress codes
  // ------------------------------------------------------------
  localparam logic [7:0] IMS_CODE_IDLE = 8'hF8;
  localparam logic [7:0] IMS_ST_START = 8'h08;
  localparam logic [7:0] IMS_ST_RSTART = 8'h10;
  localparam logic [7:0] IMS_MT_AW_ACK = 8'h18;
  localparam logic [7:0] IMS_MT_AW_NACK = 8'h20;
  localparam logic [7:0] IMS_MT_D_ACK = 8'h28;
  localparam logic [7:0] IMS_MT_D_NACK = 8'h30;
  localparam logic [7:0] IMS_ARB_LOST = 8'h38;
  localparam logic [7:0] IMS_MR_AR_ACK = 8'h40;
  localparam logic [7:0] IMS_MR_AR_NACK = 8'h48;
  localparam logic [7:0] IMS_MR_D_ACK = 8'h50;
  localparam logic [7:0] IMS_MR_D_NACK = 8'h58;
  localparam logic [7:0] IMS_SR_AW = 8'h60;
  localparam logic [7:0] IMS_SR_AW_ARB = 8'h68;
  localparam logic [7:0] IMS_SR_D_ACK = 8'h80;
  localparam logic [7:0] IMS_SR_D_NACK = 8'h88;
  localparam logic [7:0] IMS_SL_STOP = 8'hA0;
  localparam logic [7:0] IMS_ST_AR = 8'hA8;
  localparam logic [7:0] IMS_ST_AR_ARB = 8'hB0;
  localparam logic [7:0] IMS_ST_D_ACK = 8'hB8;
  localparam logic [7:0] IMS_ST_D_NACK = 8'hC0;
  localparam logic [7:0] IMS_ST_LAST = 8'hC8;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int IMS_CLK_KHZ = 50000;
  localparam int IMS_SCL_KHZ [8] = '{330, 288, 217, 146, 88, 59, 44, 36};

  // Half serial clock period in system cycles, minus one, rounded up
  function automatic logic [9:0] ims_half_cnt(input logic [2:0] rate);
    int f;
    f = IMS_SCL_KHZ[rate];
    return 10'((IMS_CLK_KHZ + 2 * f - 1) / (2 * f) - 1);
  endfunction

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {MD_NAS, MD_MTX, MD_MRX, MD_SRX, MD_STX} ims_mode_t;
  typedef enum logic [3:0] {G_IDLE, G_BUF, G_START, G_LOW, G_HIGH, G_STOP_A, G_STOP_B, G_RS_A, G_RS_B} ims_gen_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } ims_req_t;

  typedef struct packed {
    logic scl_m1;
    logic scl_m2;
    logic scl_m3;
    logic sda_m1;
    logic sda_m2;
    logic sda_m3;
    logic [7:0] control;
    logic [7:0] own;
    logic [7:0] code;
    logic [7:0] byte_r;
    logic [7:0] rdata;
    ims_mode_t mode;
    ims_gen_t gen;
    logic [9:0] div;
    logic master;
    logic lost;
    logic busy;
    logic addr_phase;
    logic armed;
    logic matched;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic got_ack;
    logic hold;
    logic scl_low;
    logic sda_low;
  } ims_state_t;

  localparam ims_state_t IMS_STATE_RST = '{control: IMS_CONTROL_RST, own: IMS_OWN_RST, code: IMS_CODE_IDLE,
                                           byte_r: IMS_BYTE_RST, mode: MD_NAS, gen: G_IDLE, default: '0};
endpackage

//--- rtl/ims_sequencer.sv
// Two-wire bus controller: master transmit/receive and slave receive/transmit sequencing.
// Assumes open-drain pads outside (output low when enabled) and a host on the register port.
`timescale 1ns/1ps

module ims_sequencer
  import ims_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire ims_req_t req,
  output logic [7:0] rdata,
  // Serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ------------------------------------------------------------
  // State and decodes
  // ------------------------------------------------------------
  ims_state_t s;
  ims_state_t n;
  logic en;
  logic flag;
  logic ack_en;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic tick;
  logic tx_bits;
  logic byte_done;
  logic set_flag;
  logic [3:0] nb;
  logic [9:0] half;

  // Control bits and bus events from the synchronised pins
  assign en = s.control[IMS_CTL_EN];
  assign flag = s.control[IMS_CTL_FLAG];
  assign ack_en = s.control[IMS_CTL_ACK];
  assign scl_rise = s.scl_m2 & ~s.scl_m3;
  assign scl_fall = ~s.scl_m2 & s.scl_m3;
  assign start_det = s.scl_m2 & s.scl_m3 & ~s.sda_m2 & s.sda_m3;
  assign stop_det = s.scl_m2 & s.scl_m3 & s.sda_m2 & ~s.sda_m3;
  assign tick = (s.div == 10'h000);
  assign half = ims_half_cnt(s.control[2:0]);
  assign nb = s.bit_cnt + 4'h1;
  assign byte_done = scl_fall & s.armed & (s.bit_cnt == IMS_ACK_BIT);
  // Who drives data bits in this byte
  assign tx_bits = (s.master & (s.addr_phase | (s.mode == MD_MTX))) | (s.mode == MD_STX);

  // Open-drain pads: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = s.scl_low | s.hold;
  assign sda_oe = s.sda_low;
  assign rdata = s.rdata;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    set_flag = 1'b0;
    // Two-stage synchronisers plus one previous sample
    n.scl_m1 = scl_in;
    n.scl_m2 = s.scl_m1;
    n.scl_m3 = s.scl_m2;
    n.sda_m1 = sda_in;
    n.sda_m2 = s.sda_m1;
    n.sda_m3 = s.sda_m2;
    // Free-running half-period divider for master clocking
    n.div = tick ? half : s.div - 10'h001;
    // Read data valid only in the cycle after the strobe
    n.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        IMS_ADDR_CONTROL: n.rdata = s.control;
        IMS_ADDR_OWN: n.rdata = s.own;
        IMS_ADDR_PROGRESS: n.rdata = {s.code[7:3], 3'b000};
        default: n.rdata = s.byte_r;
      endcase
    end

    if (!en) begin
      // Disabled: pins released, inputs ignored, not addressed
      n.mode = MD_NAS;
      n.gen = G_IDLE;
      n.master = 1'b0;
      n.lost = 1'b0;
      n.busy = 1'b0;
      n.addr_phase = 1'b0;
      n.armed = 1'b0;
      n.matched = 1'b0;
      n.bit_cnt = 4'h0;
      n.hold = 1'b0;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
      n.code = IMS_CODE_IDLE;
    end else begin
      // Master clock and condition generator
      case (s.gen)
        G_IDLE: begin
          n.scl_low = 1'b0;
          if (s.control[IMS_CTL_BEGIN] & ~s.busy & ~flag) begin
            n.gen = G_BUF;
            n.div = half;
          end
        end
        G_BUF: begin
          if (tick) begin
            if (s.busy) begin
              n.gen = G_IDLE;
            end else begin
              n.sda_low = 1'b1;
              n.gen = G_START;
            end
          end
        end
        G_START: begin
          if (tick) begin
            n.scl_low = 1'b1;
            n.gen = G_LOW;
            n.master = 1'b1;
            n.code = s.master ? IMS_ST_RSTART : IMS_ST_START;
            n.hold = 1'b1;
            set_flag = 1'b1;
          end
        end
        G_LOW: begin
          n.scl_low = 1'b1;
          // Low phase is held while the flag is pending
          if (tick & ~s.hold) begin
            if (s.control[IMS_CTL_HALT]) begin
              n.sda_low = 1'b1;
              n.gen = G_STOP_A;
            end else if (s.control[IMS_CTL_BEGIN]) begin
              n.sda_low = 1'b0;
              n.gen = G_RS_A;
            end else begin
              n.scl_low = 1'b0;
              n.gen = G_HIGH;
            end
          end
        end
        G_HIGH: begin
          // Far end may stretch: count high time only once high is seen
          if (~s.scl_m2) begin
            n.div = half;
          end else if (tick) begin
            n.scl_low = 1'b1;
            n.gen = G_LOW;
          end
        end
        G_STOP_A: begin
          if (tick) begin
            n.scl_low = 1'b0;
            n.gen = G_STOP_B;
          end
        end
        G_STOP_B: begin
          if (s.scl_m2 & tick) begin
            n.sda_low = 1'b0;
            n.gen = G_IDLE;
          end
        end
        G_RS_A: begin
          if (tick) begin
            n.scl_low = 1'b0;
            n.gen = G_RS_B;
          end
        end
        G_RS_B: begin
          if (s.scl_m2 & tick) begin
            n.sda_low = 1'b1;
            n.gen = G_START;
          end
        end
        default: n.gen = G_IDLE;
      endcase

      // Flag cleared by software: resume and present the first bit
      if (s.hold & ~flag) begin
        n.hold = 1'b0;
        n.div = half;
        n.sda_low = tx_bits & ~s.byte_r[7];
      end

      // Bit engine driven by the observed bus
      if (start_det) begin
        n.busy = 1'b1;
        n.bit_cnt = 4'h0;
        n.addr_phase = 1'b1;
        n.armed = 1'b0;
        n.lost = 1'b0;
        n.matched = 1'b0;
        if (~s.master & ((s.mode == MD_SRX) | (s.mode == MD_STX))) begin
          n.code = IMS_SL_STOP;
          set_flag = 1'b1;
          n.mode = MD_NAS;
          n.sda_low = 1'b0;
        end
      end else if (stop_det) begin
        n.busy = 1'b0;
        n.addr_phase = 1'b0;
        n.armed = 1'b0;
        n.bit_cnt = 4'h0;
        n.mode = MD_NAS;
        n.sda_low = 1'b0;
        if (s.master) begin
          // Own stop seen: halt request retires, no flag
          n.master = 1'b0;
          n.control[IMS_CTL_HALT] = 1'b0;
          n.code = IMS_CODE_IDLE;
          n.gen = G_IDLE;
          n.scl_low = 1'b0;
        end else if ((s.mode == MD_SRX) | (s.mode == MD_STX)) begin
          n.code = IMS_SL_STOP;
          set_flag = 1'b1;
        end else if (~flag) begin
          n.code = IMS_CODE_IDLE;
        end
      end else begin
        // Sample on rising clock: data shift, arbitration, acknowledge
        if (scl_rise & s.armed) begin
          if (s.bit_cnt < IMS_ACK_BIT) begin
            n.shreg = {s.shreg[6:0], s.sda_m2};
            if (s.master & tx_bits & ~s.sda_low & ~s.sda_m2) begin
              n.lost = 1'b1;
              n.master = 1'b0;
              n.gen = G_IDLE;
              n.scl_low = 1'b0;
            end
          end else begin
            n.got_ack = ~s.sda_m2;
          end
        end
        if (byte_done) begin
          // Byte plus acknowledge complete: report and hold
          n.bit_cnt = 4'h0;
          n.addr_phase = 1'b0;
          n.sda_low = 1'b0;
          n.byte_r = s.shreg;
          n.hold = 1'b1;
          set_flag = 1'b1;
          if (s.addr_phase & s.master) begin
            n.mode = s.shreg[0] ? MD_MRX : MD_MTX;
            if (s.shreg[0]) begin
              n.code = s.got_ack ? IMS_MR_AR_ACK : IMS_MR_AR_NACK;
            end else begin
              n.code = s.got_ack ? IMS_MT_AW_ACK : IMS_MT_AW_NACK;
            end
          end else if (s.addr_phase & s.matched) begin
            n.mode = s.shreg[0] ? MD_STX : MD_SRX;
            if (s.shreg[0]) begin
              n.code = s.lost ? IMS_ST_AR_ARB : IMS_ST_AR;
            end else begin
              n.code = s.lost ? IMS_SR_AW_ARB : IMS_SR_AW;
            end
            n.lost = 1'b0;
          end else if (s.lost) begin
            n.code = IMS_ARB_LOST;
            n.mode = MD_NAS;
            n.lost = 1'b0;
          end else begin
            case (s.mode)
              MD_MTX: n.code = s.got_ack ? IMS_MT_D_ACK : IMS_MT_D_NACK;
              MD_MRX: n.code = s.sda_low ? IMS_MR_D_ACK : IMS_MR_D_NACK;
              MD_SRX: begin
                n.code = s.sda_low ? IMS_SR_D_ACK : IMS_SR_D_NACK;
                if (~s.sda_low) begin
                  n.mode = MD_NAS;
                end
              end
              MD_STX: begin
                if (~s.got_ack) begin
                  n.code = IMS_ST_D_NACK;
                  n.mode = MD_NAS;
                end else if (~ack_en) begin
                  n.code = IMS_ST_LAST;
                  n.mode = MD_NAS;
                end else begin
                  n.code = IMS_ST_D_ACK;
                end
              end
              default: begin
                // Not addressed: keep watching, no report
                n.hold = 1'b0;
                set_flag = 1'b0;
              end
            endcase
          end
        end else if (scl_fall) begin
          if (~s.armed) begin
            // Falling edge that closes the start condition
            n.armed = 1'b1;
          end else begin
            n.bit_cnt = nb;
            if (nb == IMS_ACK_BIT) begin
              if (tx_bits) begin
                n.sda_low = 1'b0;
              end else if (s.addr_phase & ~s.master) begin
                n.matched = (s.shreg[7:1] == s.own[7:1]) & ack_en;
                n.sda_low = (s.shreg[7:1] == s.own[7:1]) & ack_en;
              end else begin
                n.sda_low = ack_en & ((s.mode == MD_MRX) | (s.mode == MD_SRX));
              end
            end else begin
              n.sda_low = tx_bits & ~s.byte_r[~nb[2:0]];
            end
          end
        end
      end
    end

    // Register writes; enable changes only here
    if (req.wr) begin
      case (req.addr)
        IMS_ADDR_CONTROL: begin
          n.control = req.wdata;
          n.control[IMS_CTL_FLAG] = s.control[IMS_CTL_FLAG] & req.wdata[IMS_CTL_FLAG];
        end
        IMS_ADDR_OWN: begin
          n.own = req.wdata;
          n.own[0] = 1'b0;
        end
        IMS_ADDR_BYTE: n.byte_r = req.wdata;
        default: n.code = n.code;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (set_flag) begin
      n.control[IMS_CTL_FLAG] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= IMS_STATE_RST;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_NO_FLAG_IDLE:
    assert property (@(posedge clock) disable iff (!nrst) $rose(s.control[IMS_CTL_FLAG]) |-> s.code != IMS_CODE_IDLE)
      else $error("flag raised with idle progress code");

  AST_HOLD_SUSPENDS:
    assert property (@(posedge clock) disable iff (!nrst)
      s.hold && flag && en && !start_det && !stop_det |=> scl_oe && $stable(s.bit_cnt))
      else $error("transfer advanced while flag pending");

  AST_ENABLE_SW_ONLY:
    assert property (@(posedge clock) disable iff (!nrst)
      !(req.wr && req.addr == IMS_ADDR_CONTROL) |=> $stable(s.control[IMS_CTL_EN]))
      else $error("enable bit changed without a write");

  AST_START_REPORT:
    assert property (@(posedge clock) disable iff (!nrst)
      en && s.gen == G_START && tick && !start_det && !stop_det |=>
      s.control[IMS_CTL_FLAG] && s.master && (s.code == IMS_ST_START || s.code == IMS_ST_RSTART))
      else $error("start not reported with 08H or 10H");

  AST_HALT_RETIRES:
    assert property (@(posedge clock) disable iff (!nrst)
      en && stop_det && s.master && !req.wr |=> !s.control[IMS_CTL_HALT] && !s.master ##1 !sda_oe)
      else $error("halt request not retired after own stop");

  AST_PROGRESS_LOW_ZERO:
    assert property (@(posedge clock) disable iff (!nrst)
      req.rd && req.addr == IMS_ADDR_PROGRESS |=> rdata[2:0] == 3'b000 && rdata[7:3] == $past(s.code[7:3]))
      else $error("progress code read back wrong");

  AST_OWN_ADDRESS:
    assert property (@(posedge clock) disable iff (!nrst)
      req.wr && req.addr == IMS_ADDR_OWN |=> s.own == {$past(req.wdata[7:1]), 1'b0})
      else $error("own address register layout wrong");

  AST_IGNORE_OWN:
    assert property (@(posedge clock) disable iff (!nrst)
      en && scl_fall && s.armed && nb == IMS_ACK_BIT && s.addr_phase && !s.master && !ack_en
      && !start_det && !stop_det |=> !s.matched && !sda_oe)
      else $error("own address acknowledged while acknowledge disabled");

  AST_NACK_DATA:
    assert property (@(posedge clock) disable iff (!nrst)
      en && scl_fall && s.armed && nb == IMS_ACK_BIT && !s.addr_phase && s.mode == MD_SRX && !ack_en
      && !start_det && !stop_det |=> !sda_oe)
      else $error("data acknowledged while acknowledge disabled");

  AST_MASTER_DIRECTION:
    assert property (@(posedge clock) disable iff (!nrst)
      en && byte_done && s.addr_phase && s.master && !start_det && !stop_det |=>
      s.mode == ($past(s.shreg[0]) ? MD_MRX : MD_MTX) && s.control[IMS_CTL_FLAG])
      else $error("master mode does not follow direction bit");

  AST_SLAVE_RX_ENTRY:
    assert property (@(posedge clock) disable iff (!nrst)
      en && byte_done && s.addr_phase && !s.master && s.matched && !s.lost && !s.shreg[0]
      && !start_det && !stop_det |=> s.mode == MD_SRX && s.code == IMS_SR_AW)
      else $error("own address with write did not enter slave receive");

endmodule

//--- sim/ims_sequencer_tb_top.sv
// Self-checking bench of the two-wire mode sequencer.
// Assumes rate 0 and open-drain pins resolved here with pull-ups.
`timescale 1ns/1ps
module ims_sequencer_tb_top
  import ims_pkg::*;
;
  logic clock;
  logic nrst;
  logic bm_scl;
  logic bm_sda;
  logic m_oe;
  logic scl_oe;
  logic sda_oe;
  logic [7:0] rdata;
  logic [7:0] v;
  ims_req_t req;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire scl_w = !(scl_oe | bm_scl);
  wire sda_w = !(sda_oe | m_oe | bm_sda);

  ims_sequencer u_ims_sequencer (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .scl_in(scl_w),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
  ims_slave_model u_ims_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe(m_oe));

  task automatic close_out;
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1 d = rdata;
  endtask
  // Poll flag, then compare code
  task automatic wflag(input logic [7:0] code);
    v = 8'h00;
    for (int i = 0; i < 3000 && v[3] !== 1'b1; i++) reg_rd(IMS_ADDR_CONTROL, v);
    reg_rd(IMS_ADDR_PROGRESS, v);
    chk(v, code);
  endtask
  task automatic halt;
    reg_wr(IMS_ADDR_CONTROL, 8'h50);
    repeat (600) @(posedge clock);
    reg_rd(IMS_ADDR_CONTROL, v);
    chk(v, 8'h40);
    reg_rd(IMS_ADDR_PROGRESS, v);
    chk(v, IMS_CODE_IDLE);
  endtask
  task automatic go(input logic [7:0] b, input logic [7:0] code);
    reg_wr(IMS_ADDR_BYTE, b);
    reg_wr(IMS_ADDR_CONTROL, 8'h40);
    wflag(code);
  endtask
  task automatic hp;
    repeat (4) @(posedge clock);
  endtask
  // Release clock, wait out stretching
  task automatic shigh;
    bm_scl <= 1'b0;
    for (int i = 0; i < 3000 && scl_w !== 1'b1; i++) @(posedge clock);
    hp;
  endtask
  task automatic bm_byte(input logic [7:0] b, output logic [7:0] a);
    for (int i = 7; i >= 0; i--) begin
      bm_sda <= !b[i];
      hp;
      shigh;
      bm_scl <= 1'b1;
      // Let the clock fall settle before data moves
      @(posedge clock);
    end
    bm_sda <= 1'b0;
    hp;
    shigh;
    a = {7'h00, sda_w};
    bm_scl <= 1'b1;
    hp;
  endtask
  task automatic bm_start;
    bm_sda <= 1'b1;
    hp;
    bm_scl <= 1'b1;
    hp;
  endtask
  task automatic bm_stop;
    bm_sda <= 1'b1;
    hp;
    shigh;
    bm_sda <= 1'b0;
    hp;
  endtask

  task automatic t_regs;
    reg_rd(IMS_ADDR_CONTROL, v);
    chk(v, IMS_CONTROL_RST);
    reg_wr(IMS_ADDR_PROGRESS, 8'h55);
    reg_rd(IMS_ADDR_PROGRESS, v);
    chk(v, IMS_CODE_IDLE);
    reg_wr(IMS_ADDR_OWN, 8'hA3);
    reg_rd(IMS_ADDR_OWN, v);
    chk(v, 8'hA2);
  endtask
  task automatic t_mwrite;
    reg_wr(IMS_ADDR_CONTROL, 8'h60);
    wflag(IMS_ST_START);
    go({7'h2C, 1'b0}, IMS_MT_AW_ACK);
    repeat (300) @(posedge clock);
    chk({7'h00, scl_w}, 8'h00);
    go(8'h3C, IMS_MT_D_ACK);
    chk(u_ims_slave_model.sh, 8'h3C);
    halt;
  endtask
  task automatic t_mnack;
    reg_wr(IMS_ADDR_CONTROL, 8'h60);
    wflag(IMS_ST_START);
    go({7'h33, 1'b0}, IMS_MT_AW_NACK);
    halt;
  endtask
  task automatic t_rstart;
    reg_wr(IMS_ADDR_CONTROL, 8'h60);
    wflag(IMS_ST_START);
    go({7'h2C, 1'b0}, IMS_MT_AW_ACK);
    reg_wr(IMS_ADDR_CONTROL, 8'h60);
    wflag(IMS_ST_RSTART);
    go({7'h2C, 1'b1}, IMS_MR_AR_ACK);
    reg_wr(IMS_ADDR_CONTROL, 8'h40);
    wflag(IMS_MR_D_NACK);
    reg_rd(IMS_ADDR_BYTE, v);
    chk(v, 8'hA5);
    halt;
  endtask
  task automatic t_slave;
    reg_wr(IMS_ADDR_CONTROL, 8'hC0);
    bm_start;
    bm_byte({7'h51, 1'b0}, v);
    chk(v, 8'h00);
    wflag(IMS_SR_AW);
    reg_wr(IMS_ADDR_CONTROL, 8'h40);
    bm_byte(8'h96, v);
    chk(v, 8'h01);
    wflag(IMS_SR_D_NACK);
    reg_wr(IMS_ADDR_CONTROL, 8'h40);
    bm_stop;
    bm_start;
    bm_byte({7'h51, 1'b0}, v);
    chk(v, 8'h01);
    bm_stop;
    reg_rd(IMS_ADDR_PROGRESS, v);
    chk(v, IMS_CODE_IDLE);
  endtask

  // Clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Cycle ceiling
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      close_out;
    end
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    req = '0;
    bm_scl = 1'b0;
    bm_sda = 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_mwrite;
    t_mnack;
    t_rstart;
    t_slave;
    close_out;
  end
endmodule

//--- sim/ims_slave_model.sv
// Two-wire slave model: acks its own address, acks written bytes, sends one byte on reads.
// Assumes wired-and bus levels with pull-ups built by the bench.
`timescale 1ns/1ps
module ims_slave_model #(
  parameter logic [6:0] ADDR = 7'h2C,
  parameter logic [7:0] TXB = 8'hA5
) (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Data pull-down
  output logic sda_oe
);
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00;
  logic on = 1'b0;
  logic ap = 1'b0;
  logic rd = 1'b0;
  initial sda_oe = 1'b0;
  // Start restarts framing
  always @(negedge sda) if (scl) begin
    n = 4'h0;
    on = 1'b1;
    ap = 1'b1;
    rd = 1'b0;
  end
  // Stop releases the line
  always @(posedge sda) if (scl) begin
    on = 1'b0;
    sda_oe = 1'b0;
  end
  // Shift in MSB first, decode address byte
  always @(posedge scl) if (on) begin
    if (n < 4'h8) sh = {sh[6:0], sda};
    n = n + 4'h1;
    if (n == 4'h9) begin
      n = 4'h0;
      if (rd && sda) on = 1'b0;
      if (ap) begin
        ap = 1'b0;
        rd = sh[0];
        if (sh[7:1] != ADDR) on = 1'b0;
      end
    end
  end
  // Ack low on match, else send data bits
  always @(negedge scl)
    sda_oe = on && (n == 4'h8 ? !rd && (!ap || sh[7:1] == ADDR) : rd && n < 4'h8 && !TXB[3'h7 - n[2:0]]);
endmodule
